/* File: core/frp_defines.svh */
// Purpose: constants for the flash rewrite protection block
// Assumes: APB slave with 32-bit data, byte addresses
// Notes: option byte fields follow the startup option byte layout
`ifndef FRP_DEFINES_SVH
`define FRP_DEFINES_SVH
`define FRP_ADDR_W 16
`define FRP_OPT_ADDR 16'hFFFF
`define FRP_VEC_LO_ADDR 16'hFFFC
`define FRP_VEC_MID_ADDR 16'hFFFD
`define FRP_VEC_HI_ADDR 16'hFFFE
`define FRP_VEC_ERASED 20'hFFFFF
`define FRP_ERASED_BYTE 8'hFF
`define FRP_ID_BYTES 7
`define FRP_NUM_CMDS 7
`define FRP_NUM_PBLK 6
`define FRP_BIT_WDT 0
`define FRP_BIT_RCR 2
`define FRP_BIT_RCP 3
`define FRP_BIT_VLO 4
`define FRP_BIT_VHI 5
`define FRP_BIT_VMS 6
`define FRP_BIT_CSP 7
`define FRP_OFF_CTRL 12'h000
`define FRP_OFF_LOCK 12'h004
`define FRP_OFF_CMD 12'h008
`define FRP_OFF_STAT 12'h00C
`define FRP_OFF_OPT 12'h010
`define FRP_OFF_IDCMP 12'h014
`define FRP_CTRL_RST 32'h0000_0000
`define FRP_LOCK_RST 32'h0000_003F
`endif

/* File: core/frp_pkg.sv */
// Purpose: types for the flash rewrite protection block
// Assumes: used with frp_defines.svh
// Notes: command codes are local encodings
package frp_pkg;
  typedef enum logic [2:0] {
    FRP_CMD_READ_ARRAY = 3'h0,
    FRP_CMD_PROGRAM = 3'h1,
    FRP_CMD_BLOCK_ERASE = 3'h2,
    FRP_CMD_LOCK_PROGRAM = 3'h3,
    FRP_CMD_READ_LOCK = 3'h4,
    FRP_CMD_CLEAR_STATUS = 3'h5,
    FRP_CMD_BLANK_CHECK = 3'h6
  } frp_cmd_t;
  typedef enum logic [3:0] {
    FRP_ID_IDLE = 4'b0001,
    FRP_ID_RUN = 4'b0010,
    FRP_ID_PASS = 4'b0100,
    FRP_ID_FAIL = 4'b1000
  } frp_id_st_t;
  typedef enum logic [1:0] {
    FRP_MODE_CPU = 2'h0,
    FRP_MODE_SERIAL = 2'h1,
    FRP_MODE_PARALLEL = 2'h2
  } frp_mode_t;
endpackage

/* File: core/frp_top.sv */
// Purpose: flash rewrite gating, ID check, ROM code protect, option decode
// Assumes: flash array and sequencer outside; mode, option and vector bytes are
//   on-chip signals in the clk_sys_i domain
// Notes: option byte captured once per reset
`timescale 1ns/1ps
`default_nettype none
`include "frp_defines.svh"
module frp_top #(
  parameter int NUM_PBLK = `FRP_NUM_PBLK,
  parameter int ID_BYTES = `FRP_ID_BYTES
) (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [1:0] mode_i,
  input wire logic [7:0] flash_opt_byte_i,
  input wire logic [7:0] vec_lo_i,
  input wire logic [7:0] vec_mid_i,
  input wire logic [7:0] vec_hi_i,
  input wire logic id_byte_vld_i,
  input wire logic [7:0] id_byte_i,
  input wire logic [7:0] id_ref_byte_i,
  output logic [2:0] id_ref_idx_o,
  input wire logic pgm_cmd_vld_i,
  input wire logic [2:0] pgm_cmd_i,
  input wire logic pgm_is_data_blk_i,
  input wire logic [2:0] pgm_blk_i,
  input wire logic pgm_blk_b_i,
  input wire logic opt_blk_sel_i,
  output logic flash_cmd_vld_o,
  output logic [2:0] flash_cmd_o,
  output logic cmd_reject_o,
  output logic parallel_reject_o,
  output logic watchdog_autostart_o,
  output logic [1:0] voltage_detect_0_level_o,
  output logic volt_monitor_reset_en_o,
  output logic count_source_protect_o
);
  typedef struct packed {
    logic cap_done;
    logic [7:0] opt;
    logic [NUM_PBLK-1:0] lock;
    logic data_block_a_protect;
    logic data_block_b_protect;
    frp_pkg::frp_id_st_t id_st;
    logic [2:0] id_idx;
    logic [31:0] rdata;
    logic cmd_vld;
    logic [2:0] cmd;
    logic rej;
    logic prej;
    logic [2:0] sw_cmd;
    logic sw_go;
  } frp_state_t;
  frp_state_t st_q;
  frp_state_t st_d;
  logic apb_acc;
  logic vec_erased;
  logic rom_prot;
  logic [2:0] cmd_c;
  logic cmd_prog_erase;
  logic cmd_vld_c;
  logic blk_locked;
  logic ser_block;
  logic par_block;
  logic [7:0] opt_now;
  assign apb_acc = psel_i & penable_i;
  // Erased array reads FFh in every byte
  assign opt_now = flash_opt_byte_i;
  assign vec_erased = ({vec_hi_i[3:0], vec_mid_i, vec_lo_i} == `FRP_VEC_ERASED);
  assign rom_prot = st_q.opt[`FRP_BIT_RCR] & ~st_q.opt[`FRP_BIT_RCP];
  // Software writes to the command register win over programmer ones
  assign cmd_c = st_q.sw_go ? st_q.sw_cmd : pgm_cmd_i;
  assign cmd_vld_c = st_q.sw_go | pgm_cmd_vld_i;
  assign cmd_prog_erase = (cmd_c == 3'(frp_pkg::FRP_CMD_PROGRAM)) |
                          (cmd_c == 3'(frp_pkg::FRP_CMD_BLOCK_ERASE)) |
                          (cmd_c == 3'(frp_pkg::FRP_CMD_LOCK_PROGRAM));
  always_comb
  begin
    // Software commands use the same block lines as the programmer
    blk_locked = 1'b0;
    if (pgm_is_data_blk_i)
    begin
      blk_locked = pgm_blk_b_i ? st_q.data_block_b_protect : st_q.data_block_a_protect;
    end
    else if (int'(pgm_blk_i) < NUM_PBLK)
    begin
      blk_locked = st_q.lock[pgm_blk_i];
    end
  end
  assign ser_block = (mode_i == frp_pkg::FRP_MODE_SERIAL) && !vec_erased &&
                     (st_q.id_st != frp_pkg::FRP_ID_PASS);
  assign par_block = (mode_i == frp_pkg::FRP_MODE_PARALLEL) && rom_prot;
  always_comb
  begin
    st_d = st_q;
    st_d.cmd_vld = 1'b0;
    st_d.rej = 1'b0;
    st_d.prej = 1'b0;
    st_d.sw_go = 1'b0;
    if (!st_q.cap_done)
    begin
      st_d.opt = opt_now;
      st_d.cap_done = 1'b1;
    end
    if (mode_i != frp_pkg::FRP_MODE_SERIAL)
    begin
      st_d.id_st = frp_pkg::FRP_ID_IDLE;
      st_d.id_idx = 3'h0;
    end
    else if (id_byte_vld_i && st_q.id_st != frp_pkg::FRP_ID_FAIL)
    begin
      if (id_byte_i != id_ref_byte_i)
      begin
        st_d.id_st = frp_pkg::FRP_ID_FAIL;
      end
      else if (int'(st_q.id_idx) == ID_BYTES - 1)
      begin
        st_d.id_st = frp_pkg::FRP_ID_PASS;
      end
      else
      begin
        st_d.id_st = frp_pkg::FRP_ID_RUN;
        st_d.id_idx = st_q.id_idx + 3'h1;
      end
    end
    if (cmd_vld_c)
    begin
      // Codes beyond the seven are refused as well
      if (cmd_c == 3'h7 || (!st_q.sw_go && (ser_block || par_block)) ||
          (cmd_prog_erase && blk_locked))
      begin
        st_d.rej = 1'b1;
        st_d.prej = !st_q.sw_go && par_block;
      end
      else
      begin
        st_d.cmd_vld = 1'b1;
        st_d.cmd = cmd_c;
      end
    end
    st_d.rdata = 32'h0000_0000;
    if (psel_i && !penable_i && !pwrite_i)
    begin
      unique case (paddr_i)
        `FRP_OFF_CTRL: st_d.rdata = {30'h0, st_q.data_block_b_protect,
                                     st_q.data_block_a_protect};
        `FRP_OFF_LOCK: st_d.rdata = 32'(st_q.lock);
        `FRP_OFF_CMD: st_d.rdata = {29'h0, st_q.cmd};
        `FRP_OFF_STAT: st_d.rdata = {24'h0, st_q.id_st, 1'b0, rom_prot,
                                     st_q.rej, st_q.cmd_vld};
        `FRP_OFF_OPT: st_d.rdata = {24'h0, st_q.opt};
        `FRP_OFF_IDCMP: st_d.rdata = {29'h0, st_q.id_idx};
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end
    if (apb_acc && pwrite_i)
    begin
      unique case (paddr_i)
        `FRP_OFF_CTRL:
        begin
          st_d.data_block_a_protect = pwdata_i[0];
          st_d.data_block_b_protect = pwdata_i[1];
        end
        `FRP_OFF_LOCK: st_d.lock = pwdata_i[NUM_PBLK-1:0];
        `FRP_OFF_CMD:
        begin
          st_d.sw_cmd = pwdata_i[2:0];
          st_d.sw_go = 1'b1;
        end
        default:
        begin
        end
      endcase
    end
  end
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st_q <= '{cap_done: 1'b0, opt: `FRP_ERASED_BYTE,
                lock: NUM_PBLK'(`FRP_LOCK_RST), data_block_a_protect: 1'b0,
                data_block_b_protect: 1'b0, id_st: frp_pkg::FRP_ID_IDLE,
                id_idx: 3'h0, rdata: 32'h0000_0000, cmd_vld: 1'b0, cmd: 3'h0,
                rej: 1'b0, prej: 1'b0, sw_cmd: 3'h0, sw_go: 1'b0};
    end
    else
    begin
      st_q <= st_d;
    end
  end
  assign prdata_o = st_q.rdata;
  assign pready_o = 1'b1;
  assign pslverr_o = apb_acc && (paddr_i[1:0] != 2'h0 || paddr_i > `FRP_OFF_IDCMP);
  assign id_ref_idx_o = st_q.id_idx;
  assign flash_cmd_vld_o = st_q.cmd_vld;
  assign flash_cmd_o = st_q.cmd;
  assign cmd_reject_o = st_q.rej;
  assign parallel_reject_o = st_q.prej;
  assign watchdog_autostart_o = ~st_q.opt[`FRP_BIT_WDT];
  assign voltage_detect_0_level_o = {st_q.opt[`FRP_BIT_VHI], st_q.opt[`FRP_BIT_VLO]};
  assign volt_monitor_reset_en_o = ~st_q.opt[`FRP_BIT_VMS];
  assign count_source_protect_o = ~st_q.opt[`FRP_BIT_CSP];
  // Command cases, command outcomes and ID steps used by the checks below
  sequence s_cmd_refused;
    cmd_reject_o && !flash_cmd_vld_o;
  endsequence
  sequence s_cmd_passed;
    flash_cmd_vld_o && !cmd_reject_o;
  endsequence
  sequence s_bad_code;
    cmd_vld_c && cmd_c == 3'h7;
  endsequence
  sequence s_sw_clean;
    st_q.sw_go && st_q.sw_cmd != 3'h7 && !(cmd_prog_erase && blk_locked);
  endsequence
  sequence s_id_mismatch;
    mode_i == 2'h1 && id_byte_vld_i && st_q.id_st != frp_pkg::FRP_ID_FAIL &&
    id_byte_i != id_ref_byte_i;
  endsequence
  sequence s_id_last_match;
    mode_i == 2'h1 && id_byte_vld_i && st_q.id_st != frp_pkg::FRP_ID_FAIL &&
    id_byte_i == id_ref_byte_i && int'(st_q.id_idx) == ID_BYTES - 1;
  endsequence
  chk_opt_hold: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    $past(st_q.cap_done) |-> $stable(st_q.opt)) else $error("option byte changed");
  chk_wdt_decode: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    watchdog_autostart_o != st_q.opt[0]) else $error("watchdog decode");
  chk_vmon_decode: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    volt_monitor_reset_en_o == !st_q.opt[6]) else $error("monitor decode");
  chk_csp_decode: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    count_source_protect_o == !st_q.opt[7]) else $error("count source decode");
  chk_vdet_decode: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    voltage_detect_0_level_o == st_q.opt[5:4]) else $error("level decode");
  chk_rom_prot: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    rom_prot == (st_q.opt[2] && !st_q.opt[3])) else $error("protect decode");
  chk_par_reject: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (pgm_cmd_vld_i && !st_q.sw_go && par_block) |=> s_cmd_refused)
    else $error("parallel access passed");
  chk_lock_block: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (cmd_vld_c && cmd_prog_erase && blk_locked) |=> !flash_cmd_vld_o)
    else $error("locked block rewritten");
  chk_id_refuse: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (pgm_cmd_vld_i && !st_q.sw_go && mode_i == 2'h1 && !vec_erased &&
     st_q.id_st == frp_pkg::FRP_ID_FAIL) |=> cmd_reject_o)
    else $error("serial command after id fail");
  chk_vec_skip: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (mode_i == 2'h1 && vec_erased) |-> !ser_block) else $error("id check not skipped");
  chk_code_refuse: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    s_bad_code |=> s_cmd_refused)
    else $error("reserved code accepted");
  chk_sw_accept: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    s_sw_clean |=> s_cmd_passed)
    else $error("software command lost");
  chk_pulse_excl: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    !(flash_cmd_vld_o && cmd_reject_o))
    else $error("accept and refuse together");
  chk_id_fail: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    s_id_mismatch |=> st_q.id_st == frp_pkg::FRP_ID_FAIL)
    else $error("id mismatch not caught");
  chk_id_sticky: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (mode_i == 2'h1 && st_q.id_st == frp_pkg::FRP_ID_FAIL) |=> st_q.id_st == frp_pkg::FRP_ID_FAIL)
    else $error("id failure cleared in serial mode");
  chk_id_pass: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    s_id_last_match |=> st_q.id_st == frp_pkg::FRP_ID_PASS)
    else $error("full id match not passed");
  chk_id_leave: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (mode_i != 2'h1) |=> st_q.id_st == frp_pkg::FRP_ID_IDLE)
    else $error("id state kept outside serial mode");
  chk_par_erase: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (pgm_cmd_vld_i && !st_q.sw_go && mode_i == 2'h2 && rom_prot &&
     pgm_cmd_i == 3'(frp_pkg::FRP_CMD_BLOCK_ERASE)) |=> s_cmd_refused)
    else $error("parallel erase lifted protection");
  chk_par_flag: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    parallel_reject_o |-> cmd_reject_o)
    else $error("parallel flag without refusal");
  chk_data_lock: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (cmd_vld_c && cmd_prog_erase && pgm_is_data_blk_i &&
     (pgm_blk_b_i ? st_q.data_block_b_protect : st_q.data_block_a_protect))
    |=> !flash_cmd_vld_o) else $error("protected data block rewritten");
  chk_cap_once: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    st_q.cap_done |=> st_q.cap_done)
    else $error("option capture repeated");
endmodule
`default_nettype wire

/* File: testbench/frp_prog_model.sv */
// Purpose: external programmer model plus the stored ID bytes it is checked against
// Assumes: seven ID bytes or one command per call, launched just after a clock edge
// Notes: released ID byte, command code and block number lines carry inverted data so stale sampling shows up
`timescale 1ns/1ps
`default_nettype none
module frp_prog_model (
  input wire logic clk_sys_i,
  input wire logic [2:0] id_ref_idx_i,
  output logic [7:0] id_ref_byte_o,
  output logic id_byte_vld_o,
  output logic [7:0] id_byte_o,
  output logic pgm_cmd_vld_o,
  output logic [2:0] pgm_cmd_o,
  output logic pgm_is_data_blk_o,
  output logic [2:0] pgm_blk_o,
  output logic pgm_blk_b_o
);
  // Stored ID values are arbitrary
  logic [7:0] id_mem [7] = '{8'h3C, 8'h4D, 8'h5E, 8'h6F, 8'h70, 8'h81, 8'h92};
  assign id_ref_byte_o = (id_ref_idx_i < 3'h7) ? id_mem[id_ref_idx_i] : 8'hA5;
  initial
  begin
    id_byte_vld_o = 1'b0;
    id_byte_o = 8'h00;
    pgm_cmd_vld_o = 1'b0;
    pgm_cmd_o = 3'h0;
    pgm_is_data_blk_o = 1'b0;
    pgm_blk_o = 3'h0;
    pgm_blk_b_o = 1'b0;
  end
  // Seven bytes, one every other cycle; bad picks a byte to corrupt
  task automatic send_id(input int bad);
    for (int i = 0; i < 7; i++)
    begin
      @(posedge clk_sys_i);
      id_byte_vld_o <= 1'b1;
      id_byte_o <= (i == bad) ? ~id_mem[i] : id_mem[i];
      @(posedge clk_sys_i);
      id_byte_vld_o <= 1'b0;
      id_byte_o <= ~id_byte_o;
    end
  endtask
  task automatic send_cmd(input logic [2:0] c, input logic d, input logic [2:0] k,
                          input logic b);
    @(posedge clk_sys_i);
    pgm_cmd_vld_o <= 1'b1;
    pgm_cmd_o <= c;
    pgm_is_data_blk_o <= d;
    pgm_blk_o <= k;
    pgm_blk_b_o <= b;
    @(posedge clk_sys_i);
    pgm_cmd_vld_o <= 1'b0;
    pgm_cmd_o <= ~c;
    pgm_blk_o <= ~k;
  endtask
endmodule
`default_nettype wire

/* File: testbench/test_flash_rewrite_protection.sv */
// Purpose: self-checking bench for frp_top against a reference model
// Assumes: zero-wait APB, command answer registered on the taking edge
// Notes: option byte is changed after capture to prove it is held
`timescale 1ns/1ps
`default_nettype none
module test_flash_rewrite_protection;
  logic clk_sys_i, resetn_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rnd, rd, ctrl_m, lock_m;
  logic [1:0] mode_i, lvl_o;
  logic [7:0] opt_i, opt_m, vlo, vmid, vhi, idb, idr;
  logic [2:0] idx, pc, pk, fc, c;
  logic idv, pv, pd, pb, fv, rej, prej, wdt, vm, csp, err, ok, id_ok;
  int error_cnt = 0, total_checks = 0, cyc = 0, m;
  frp_top u_frp_top (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .mode_i(mode_i),
    .flash_opt_byte_i(opt_i), .vec_lo_i(vlo), .vec_mid_i(vmid), .vec_hi_i(vhi),
    .id_byte_vld_i(idv), .id_byte_i(idb), .id_ref_byte_i(idr), .id_ref_idx_o(idx),
    .pgm_cmd_vld_i(pv), .pgm_cmd_i(pc), .pgm_is_data_blk_i(pd), .pgm_blk_i(pk),
    .pgm_blk_b_i(pb), .opt_blk_sel_i(1'b0), .flash_cmd_vld_o(fv), .flash_cmd_o(fc),
    .cmd_reject_o(rej), .parallel_reject_o(prej), .watchdog_autostart_o(wdt),
    .voltage_detect_0_level_o(lvl_o), .volt_monitor_reset_en_o(vm),
    .count_source_protect_o(csp));
  frp_prog_model u_frp_prog_model (.clk_sys_i(clk_sys_i), .id_ref_idx_i(idx),
    .id_ref_byte_o(idr), .id_byte_vld_o(idv), .id_byte_o(idb), .pgm_cmd_vld_o(pv),
    .pgm_cmd_o(pc), .pgm_is_data_blk_o(pd), .pgm_blk_o(pk), .pgm_blk_b_o(pb));
  initial
  begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end
  function automatic logic [31:0] rand32();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd;
  endfunction
  function automatic logic exp_ok(input logic [2:0] c, input logic d, input logic [2:0] k,
                                  input logic b);
    if (c == 3'h7)
      return 1'b0;
    if (m == 1 && {vhi[3:0], vmid, vlo} != 20'hFFFFF && !id_ok)
      return 1'b0;
    if (m == 2 && opt_m[2] && !opt_m[3])
      return 1'b0;
    return !locked(c, d, k, b);
  endfunction
  // Program, erase and lock-program hit the locks; blocks past 5 have none
  function automatic logic locked(input logic [2:0] c, input logic d, input logic [2:0] k,
                                  input logic b);
    if (c != 3'h1 && c != 3'h2 && c != 3'h3)
      return 1'b0;
    if (d)
      return ctrl_m[b];
    return (k < 3'h6) && lock_m[k];
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    @(posedge clk_sys_i);
    while (pready_o !== 1'b1)
      @(posedge clk_sys_i);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic chk_opt();
    chk("wdt", !opt_m[0], wdt);
    chk("lvl", opt_m[5:4], lvl_o);
    chk("vmon", !opt_m[6], vm);
    chk("csp", !opt_m[7], csp);
  endtask
  task automatic report_and_stop();
    if (error_cnt == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    {resetn_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, mode_i} = '0;
    {opt_i, vlo, vmid, vhi} = '1;
    rnd = 32'h81C1;
    for (int r = 0; r < 6; r++)
    begin
      if (r != 0)
        @(posedge clk_sys_i);
      opt_m = (r == 0) ? 8'hFF : (r == 1) ? 8'hF7 : 8'(rand32());
      resetn_i <= 1'b0;
      mode_i <= 2'h0;
      opt_i <= opt_m;
      repeat (4) @(posedge clk_sys_i);
      chk("rst_wdt", 1'b0, wdt);
      resetn_i <= 1'b1;
      {ctrl_m, lock_m, id_ok} = {32'h0, 32'h3F, 1'b0};
      repeat (2) @(posedge clk_sys_i);
      opt_i <= ~opt_m;
      #1 chk_opt();
      apb(1'b0, 12'h010, 32'h0);
      chk("opt_reg", opt_m, rd);
      apb(1'b0, 12'h004, 32'h0);
      chk("lock_rst", 32'h3F, rd);
      apb(1'b0, 12'h018, 32'h0);
      chk("unmapped", 1'b1, err);
      ctrl_m = rand32() & 32'h3;
      lock_m = rand32() & 32'h3F;
      apb(1'b1, 12'h000, ctrl_m);
      apb(1'b1, 12'h004, lock_m);
      apb(1'b0, 12'h000, 32'h0);
      chk("ctrl_rd", ctrl_m, rd);
      c = 3'(rand32() % 7);
      apb(1'b1, 12'h008, {29'h0, c});
      // Software target comes from the idle programmer block lines
      ok = !locked(c, pd, pk, pb);
      @(posedge clk_sys_i);
      #1 chk("sw_vld", ok, fv);
      chk("sw_rej", !ok, rej);
      if (ok)
        chk("sw_code", c, fc);
      for (m = 1; m < 3; m++)
      begin
        @(posedge clk_sys_i);
        mode_i <= 2'(m);
        id_ok = 1'b0;
        vlo <= (r % 3 == 0) ? 8'hFF : 8'hFE;
        vhi <= 8'h0F;
        // Model reads the vector bytes, so let them settle first
        @(posedge clk_sys_i);
        if (m == 1 && r % 2 == 1)
        begin
          u_frp_prog_model.send_id((r == 3) ? 4 : -1);
          id_ok = (r != 3);
        end
        for (int j = 0; j < 8; j++)
        begin
          rd = rand32();
          ok = exp_ok(rd[2:0], rd[3], 3'(rd[10:8] % 6), rd[4]);
          u_frp_prog_model.send_cmd(rd[2:0], rd[3], 3'(rd[10:8] % 6), rd[4]);
          #1 chk("accept", ok, fv);
          chk("reject", !ok, rej);
          if (ok)
            chk("code", rd[2:0], fc);
          if (rd[2:0] != 3'h7)
            chk("par_rej", m == 2 && opt_m[2] && !opt_m[3], prej);
        end
      end
      chk_opt();
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
